// ==== design/mcu_interrupt_controller.v ====
// interrupt controller with wishbone register access and core vectoring
`include "irq_ctrl_map.vh"
module mcu_interrupt_controller (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// pins
	input wire external_irq_pin_i,
	input wire [3:0] port_b_high_i,
	// on-chip sources
	input wire [7:0] timer0_count_i,
	input wire [8:0] periph_event_i,
	// processor core
	input wire [12:0] pc_i,
	input wire sleep_i,
	input wire return_from_irq_instr_i,
	output reg push_o,
	output reg [12:0] push_pc_o,
	output reg pc_load_o,
	output reg [12:0] pc_load_addr_o,
	output reg pop_o,
	output reg wake_o,
	// system interrupt
	output reg irq_o
);

localparam ST_IDLE = 2'd0;
localparam ST_WAIT = 2'd1;

function hit;
	input [7:0] adr;
	input [7:0] off;
	begin
		hit = (adr[7:2] == off[7:2]);
	end
endfunction

// registers
reg [7:0] interrupt_control;
reg [7:0] peripheral_flags_1;
reg peripheral_flags_2;
reg [7:0] peripheral_enables_1;
reg peripheral_enables_2;
reg [7:0] option_reg;
reg [2:0] sys_status;
reg [2:0] sys_enable;

// internal state
reg [1:0] q_phase;
reg [1:0] state;
reg [1:0] wait_cnt;
reg [7:0] timer0_prev;
reg sleep_q;
reg ext_en_at_sleep;
reg woke;

// next values
reg [7:0] next_control;
reg [7:0] next_pflags1;
reg next_pflags2;
reg [2:0] next_sys_status;
reg [7:0] rd_byte;

wire [4:0] pin_level;
wire [4:0] pin_change;

pin_sync #(
	.W(5)
) u_pin_sync (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.pin_i({port_b_high_i, external_irq_pin_i}),
	.level_o(pin_level),
	.change_o(pin_change)
);

// bus decode: write lands on the edge where ack is seen high
wire bus_req = wb_cyc_i & wb_stb_i;
wire wr_en = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
wire [7:0] wdat = wb_dat_i[7:0];
wire instr_en = (q_phase == `Q_PER_INSTR);
wire bus_take = bus_req & ~wb_ack_o;

// one write strobe per register
wire wr_control = wr_en & hit(wb_adr_i, `OFF_CONTROL);
wire wr_pflags1 = wr_en & hit(wb_adr_i, `OFF_PFLAGS1);
wire wr_pflags2 = wr_en & hit(wb_adr_i, `OFF_PFLAGS2);
wire wr_penable1 = wr_en & hit(wb_adr_i, `OFF_PENABLE1);
wire wr_penable2 = wr_en & hit(wb_adr_i, `OFF_PENABLE2);
wire wr_option = wr_en & hit(wb_adr_i, `OFF_OPTION);
wire wr_sys_clear = wr_en & hit(wb_adr_i, `OFF_SYS_CLEAR);
wire wr_sys_enable = wr_en & hit(wb_adr_i, `OFF_SYS_ENABLE);

// source events
wire ext_edge = pin_change[0] &
	(pin_level[0] == option_reg[`BIT_EXT_EDGE_SELECT]);
wire port_change = |pin_change[4:1];
wire timer0_ovf = (timer0_prev == 8'hff) & (timer0_count_i == 8'h00);

// enabled requests
// flag bits 2:0 pair with enable bits 5:3
wire [2:0] fixed_req;
genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_fixed_req
		assign fixed_req[gi] = interrupt_control[gi] & interrupt_control[gi + `BIT_PORT_CHANGE_EN];
	end
endgenerate
wire t0_req = fixed_req[`BIT_TIMER0_FLAG];
wire pc_req = fixed_req[`BIT_PORT_CHANGE_FLAG];
wire ext_req = fixed_req[`BIT_EXT_PIN_FLAG];
wire periph_pend = |(peripheral_flags_1 & peripheral_enables_1) |
	(peripheral_flags_2 & peripheral_enables_2);
wire periph_req = periph_pend & interrupt_control[`BIT_PERIPH_GROUP_EN];
wire any_req = t0_req | pc_req | ext_req | periph_req;
wire take_req = interrupt_control[`BIT_GLOBAL_EN] & any_req & ~sleep_i;

// sleep wake-up: pin uses the enable captured at sleep entry
wire ext_wake = interrupt_control[`BIT_EXT_PIN_FLAG] & ext_en_at_sleep;
wire wake_src = t0_req | pc_req | ext_wake | periph_req;
wire sleep_entry = sleep_i & ~sleep_q;
// one wake per sleep period, however long the source stays set
wire wake_now = sleep_i & sleep_q & wake_src & ~woke;

// vectoring fires at the end of the waiting instruction cycles
wire vector_fire = (state == ST_WAIT) & instr_en & (wait_cnt == 2'd0);

// flag and enable update
always @* begin
	next_control = interrupt_control;
	next_pflags1 = peripheral_flags_1;
	next_pflags2 = peripheral_flags_2;
	if (wr_control) begin
		next_control = wdat;
	end
	if (wr_pflags1) begin
		next_pflags1 = wdat;
	end
	if (wr_pflags2) begin
		next_pflags2 = wdat[0];
	end
	// events win over a same-cycle software clear
	if (port_change) begin
		next_control[`BIT_PORT_CHANGE_FLAG] = 1'b1;
	end
	if (ext_edge) begin
		next_control[`BIT_EXT_PIN_FLAG] = 1'b1;
	end
	if (timer0_ovf) begin
		next_control[`BIT_TIMER0_FLAG] = 1'b1;
	end
	next_pflags1 = next_pflags1 | periph_event_i[7:0];
	next_pflags2 = next_pflags2 | periph_event_i[8];
	if (vector_fire) begin
		next_control[`BIT_GLOBAL_EN] = 1'b0;
	end else if (return_from_irq_instr_i) begin
		next_control[`BIT_GLOBAL_EN] = 1'b1;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		interrupt_control <= `RST_CONTROL;
		peripheral_flags_1 <= `RST_PFLAGS;
		peripheral_flags_2 <= 1'b0;
		peripheral_enables_1 <= `RST_PENABLE;
		peripheral_enables_2 <= 1'b0;
		option_reg <= `RST_OPTION;
	end else begin
		interrupt_control <= next_control;
		peripheral_flags_1 <= next_pflags1;
		peripheral_flags_2 <= next_pflags2;
		if (wr_penable1) begin
			peripheral_enables_1 <= wdat;
		end
		if (wr_penable2) begin
			peripheral_enables_2 <= wdat[0];
		end
		if (wr_option) begin
			option_reg <= wdat;
		end
	end
end

// instruction cycle divider: one enable pulse every four clocks
always @(posedge clk_i) begin
	if (rst_i) begin
		q_phase <= 2'd0;
	end else begin
		q_phase <= q_phase + 2'd1;
	end
end

// previous timer count, an overflow is ff followed by 00
always @(posedge clk_i) begin
	if (rst_i) begin
		timer0_prev <= 8'h00;
	end else begin
		timer0_prev <= timer0_count_i;
	end
end

// vector sequencer: only the return PC is pushed
// a pending vector completes even if the global enable is cleared meanwhile
always @(posedge clk_i) begin
	if (rst_i) begin
		state <= ST_IDLE;
		wait_cnt <= 2'd0;
		push_o <= 1'b0;
		push_pc_o <= 13'h0000;
		pc_load_o <= 1'b0;
		pc_load_addr_o <= `VECTOR_ADDR;
		pop_o <= 1'b0;
	end else begin
		push_o <= 1'b0;
		pc_load_o <= 1'b0;
		pop_o <= return_from_irq_instr_i;
		case (state)
			ST_IDLE: begin
				if (instr_en && take_req) begin
					state <= ST_WAIT;
					wait_cnt <= `VEC_WAIT_CYCLES;
				end
			end
			ST_WAIT: begin
				if (instr_en) begin
					if (wait_cnt == 2'd0) begin
						state <= ST_IDLE;
						push_o <= 1'b1;
						push_pc_o <= pc_i;
						pc_load_o <= 1'b1;
						pc_load_addr_o <= `VECTOR_ADDR;
					end else begin
						wait_cnt <= wait_cnt - 2'd1;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

// sleep tracking and wake pulse
always @(posedge clk_i) begin
	if (rst_i) begin
		sleep_q <= 1'b0;
		ext_en_at_sleep <= 1'b0;
		woke <= 1'b0;
		wake_o <= 1'b0;
	end else begin
		sleep_q <= sleep_i;
		wake_o <= 1'b0;
		if (sleep_entry) begin
			ext_en_at_sleep <= interrupt_control[`BIT_EXT_PIN_EN];
		end
		if (!sleep_i) begin
			woke <= 1'b0;
		end else if (wake_now) begin
			wake_o <= 1'b1;
			woke <= 1'b1;
		end
	end
end

// system interrupt status: set wins over clear
always @* begin
	next_sys_status = sys_status;
	if (wr_sys_clear) begin
		next_sys_status = sys_status & ~wdat[2:0];
	end
	if (vector_fire) begin
		next_sys_status[`SYS_VECTOR] = 1'b1;
	end
	if (wake_now) begin
		next_sys_status[`SYS_WAKE] = 1'b1;
	end
	if (return_from_irq_instr_i) begin
		next_sys_status[`SYS_RETURN] = 1'b1;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		sys_status <= 3'b000;
		sys_enable <= 3'b000;
		irq_o <= 1'b0;
	end else begin
		sys_status <= next_sys_status;
		if (wr_sys_enable) begin
			sys_enable <= wdat[2:0];
		end
		irq_o <= |(next_sys_status & sys_enable);
	end
end

// read mux, unmapped offsets read zero
always @* begin
	rd_byte = 8'h00;
	if (hit(wb_adr_i, `OFF_CONTROL)) begin
		rd_byte = interrupt_control;
	end else if (hit(wb_adr_i, `OFF_PFLAGS1)) begin
		rd_byte = peripheral_flags_1;
	end else if (hit(wb_adr_i, `OFF_PFLAGS2)) begin
		rd_byte = {7'h00, peripheral_flags_2};
	end else if (hit(wb_adr_i, `OFF_PENABLE1)) begin
		rd_byte = peripheral_enables_1;
	end else if (hit(wb_adr_i, `OFF_PENABLE2)) begin
		rd_byte = {7'h00, peripheral_enables_2};
	end else if (hit(wb_adr_i, `OFF_OPTION)) begin
		rd_byte = option_reg;
	end else if (hit(wb_adr_i, `OFF_CORE_STATE)) begin
		rd_byte = {5'h00, ext_en_at_sleep, (state != ST_IDLE), sleep_q};
	end else if (hit(wb_adr_i, `OFF_SYS_STATUS)) begin
		rd_byte = {5'h00, sys_status};
	end else if (hit(wb_adr_i, `OFF_SYS_ENABLE)) begin
		rd_byte = {5'h00, sys_enable};
	end
end

// wishbone answer one cycle after the request
always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
	end else begin
		wb_ack_o <= bus_take;
		if (bus_take) begin
			wb_dat_o <= {24'h000000, rd_byte};
		end
	end
end

endmodule

// ==== design/irq_ctrl_map.vh ====
// register map, field positions and timing constants of the interrupt controller
// Notes on behaviour
// - twelve sources, each with its own flag bit and enable bit.
// - flags set on their event whatever any enable says.
// - global enable bit 7 passes unmasked requests when set, blocks all when clear.
// - global enable plus flag and enable set takes the vector two instruction cycles after the next instruction boundary.
// - reset clears the global enable.
// - return-from-interrupt pops the return address and sets the global enable.
// - on acceptance clear global enable, push return PC, load PC with 0004h.
// - peripheral flags and enables in two register pairs, gated by group enable.
// - pin and port-change events vector after three or four instruction cycles.
// - pin edge-triggered; option bit 6 picks rising when 1, falling when 0.
// - valid pin edge sets control bit 1; control bit 4 enables it.
// - pin wakes from sleep only if enabled before sleep; global enable decides vector.
// - timer-0 overflow FFh to 00h sets control bit 2; bit 5 enables it.
// - port B pins 7..4 change sets control bit 0; bit 3 enables it.
// - hardware saves only the return PC; software saves the rest.
// - an interrupt wake-up leaves at least one flag bit set.
// - wake-up with global enable set loads the PC with 0004h.
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// word offsets (byte addresses)
`define OFF_CONTROL 8'h00
`define OFF_PFLAGS1 8'h04
`define OFF_PFLAGS2 8'h08
`define OFF_PENABLE1 8'h0c
`define OFF_PENABLE2 8'h10
`define OFF_OPTION 8'h14
`define OFF_CORE_STATE 8'h18
`define OFF_SYS_STATUS 8'h1c
`define OFF_SYS_CLEAR 8'h20
`define OFF_SYS_ENABLE 8'h24

// interrupt_control fields, plus the option_reg edge select bit
`define BIT_PORT_CHANGE_FLAG 0
`define BIT_EXT_PIN_FLAG 1
`define BIT_TIMER0_FLAG 2
`define BIT_PORT_CHANGE_EN 3
`define BIT_EXT_PIN_EN 4
`define BIT_TIMER0_EN 5
`define BIT_PERIPH_GROUP_EN 6
`define BIT_GLOBAL_EN 7
`define BIT_EXT_EDGE_SELECT 6

// reset values
`define RST_CONTROL 8'h00
`define RST_PFLAGS 8'h00
`define RST_PENABLE 8'h00
`define RST_OPTION 8'hff

// system status bits
`define SYS_VECTOR 0
`define SYS_WAKE 1
`define SYS_RETURN 2

// core interface constants
`define VECTOR_ADDR 13'h0004
`define Q_PER_INSTR 2'd3
`define VEC_WAIT_CYCLES 2'd1

`endif

// ==== design/pin_sync.v ====
// three-stage synchroniser with agreement filter and change pulse
module pin_sync #(
	parameter W = 5
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// asynchronous pins
	input wire [W-1:0] pin_i,
	// filtered level and change pulse per bit
	output reg [W-1:0] level_o,
	output reg [W-1:0] change_o
);

reg [W-1:0] s1;
reg [W-1:0] s2;
reg [W-1:0] s3;
reg primed;
reg [2:0] fill;

always @(posedge clk_i) begin
	if (rst_i) begin
		s1 <= {W{1'b0}};
		s2 <= {W{1'b0}};
		s3 <= {W{1'b0}};
		level_o <= {W{1'b0}};
		change_o <= {W{1'b0}};
		primed <= 1'b0;
		fill <= 3'b000;
	end else begin
		fill <= {fill[1:0], 1'b1};
		s1 <= pin_i;
		s2 <= s1;
		s3 <= s2;
		change_o <= {W{1'b0}};
		// first agreement after reset only loads the level
		if (!primed) begin
			// wait until the third stage holds a real pin sample
			if (fill[2] && (s2 == s3)) begin
				level_o <= s2;
				primed <= 1'b1;
			end
		end else begin
			level_o <= (s2 & ~(s2 ^ s3)) | (level_o & (s2 ^ s3));
			change_o <= ~(s2 ^ s3) & (s2 ^ level_o);
		end
	end
end

endmodule

// ==== dv/irq_ctrl_monitor.sv ====
// port assertions for the interrupt controller
module irq_ctrl_monitor (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// watched ports
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire sleep_i,
	input wire return_from_irq_instr_i,
	input wire [12:0] pc_i,
	input wire push_o,
	input wire [12:0] push_pc_o,
	input wire pc_load_o,
	input wire [12:0] pc_load_addr_o,
	input wire pop_o,
	input wire wake_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_vector_pair: assert property (push_o == pc_load_o)
		else $error("push and load apart");
	chk_vector_addr: assert property (pc_load_o |-> pc_load_addr_o == 13'h0004)
		else $error("wrong vector");
	chk_return_pop: assert property (return_from_irq_instr_i |=> pop_o)
		else $error("no pop after return");
	chk_pop_cause: assert property (pop_o |-> $past(return_from_irq_instr_i))
		else $error("pop without return");
	chk_push_pc: assert property (push_o |-> push_pc_o == $past(pc_i))
		else $error("pushed pc wrong");
	chk_wake_sleep: assert property (wake_o |-> $past(sleep_i) && !$past(wake_o))
		else $error("wake outside sleep");
endmodule

// ==== dv/core_model.sv ====
// core sequencer stand-in: program counter, vector load, return pulse
module core_model (
	// clock
	input wire clk_i,
	// bench request
	input wire ret_req_i,
	// from controller
	input wire push_i,
	input wire pc_load_i,
	input wire [12:0] pc_load_addr_i,
	// to controller, and vector count to bench
	output logic [12:0] pc_o,
	output logic return_from_irq_instr_o,
	output int vec_count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pc_o = 13'h0100;
		return_from_irq_instr_o = 1'b0;
		vec_count_o = 0;
	end
	always @(posedge clk_i) begin
		pc_o <= pc_load_i ? pc_load_addr_i : pc_o + 13'h0001;
		return_from_irq_instr_o <= ret_req_i;
		if (push_i) begin
			vec_count_o <= vec_count_o + 1;
		end
	end
endmodule

// ==== dv/tb_mcu_interrupt_controller.sv ====
// register and vectoring tests of the interrupt controller
module tb_mcu_interrupt_controller;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00, timer0_count_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1, port_b_high_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, external_irq_pin_i = 0, sleep_i = 0, return_from_irq_instr_i, ret_req = 0;
	logic [8:0] periph_event_i = 9'h000;
	logic [12:0] pc_i, push_pc_o, pc_load_addr_o;
	logic push_o, pc_load_o, pop_o, wake_o, irq_o;
	int err_count = 0, checks_done = 0, vecs, wakes = 0;
	logic [31:0] q;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (wake_o === 1'b1) wakes <= wakes + 1;
	mcu_interrupt_controller mcu_interrupt_controller_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .external_irq_pin_i,
		.port_b_high_i, .timer0_count_i, .periph_event_i, .pc_i, .sleep_i, .return_from_irq_instr_i, .push_o,
		.push_pc_o, .pc_load_o, .pc_load_addr_o, .pop_o, .wake_o, .irq_o);
	core_model core_model_i (.clk_i, .ret_req_i(ret_req), .push_i(push_o), .pc_load_i(pc_load_o),
		.pc_load_addr_i(pc_load_addr_o), .pc_o(pc_i), .return_from_irq_instr_o(return_from_irq_instr_i), .vec_count_o(vecs));
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one classic cycle, request held until ack is sampled
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("[ERR] %0t bus answer timed out", $time);
		end
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(0, a, 8'h00);
		check(q, {24'h0, e});
	endtask
	task automatic wait_cnt(input bit w, input int want);
		int n;
		n = 0;
		while ((w ? wakes : vecs) != want && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 100) begin
			err_count++;
			$display("[ERR] %0t event count timed out", $time);
		end
	endtask
	task automatic pev(input logic [8:0] v);
		periph_event_i <= v;
		tick(1);
		periph_event_i <= 9'h000;
		tick(1);
	endtask
	initial begin
		tick(6);
		rst_i <= 0;
		tick(5);
		rd(8'h00, 8'h00);
		rd(8'h14, 8'hff);
		rd(8'h3c, 8'h00);
		timer0_count_i <= 8'hff;
		tick(1);
		timer0_count_i <= 8'h00;
		tick(2);
		rd(8'h00, 8'h04);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h00);
		external_irq_pin_i <= 1;
		tick(6);
		rd(8'h00, 8'h02);
		wr(8'h00, 8'h00);
		wr(8'h14, 8'hbf);
		external_irq_pin_i <= 0;
		tick(6);
		rd(8'h00, 8'h02);
		wr(8'h00, 8'h00);
		external_irq_pin_i <= 1;
		tick(6);
		rd(8'h00, 8'h00);
		port_b_high_i <= 4'h8;
		tick(6);
		rd(8'h00, 8'h01);
		wr(8'h00, 8'h00);
		pev(9'h001);
		rd(8'h04, 8'h01);
		wr(8'h0c, 8'h01);
		wr(8'h00, 8'h40);
		wr(8'h24, 8'h01);
		tick(20);
		check(vecs, 0);
		wr(8'h00, 8'hc0);
		wait_cnt(0, 1);
		rd(8'h00, 8'h40);
		tick(1);
		check({31'h0, irq_o}, 1);
		wr(8'h20, 8'h01);
		tick(2);
		check({31'h0, irq_o}, 0);
		wr(8'h04, 8'h00);
		ret_req <= 1;
		tick(1);
		ret_req <= 0;
		tick(3);
		rd(8'h00, 8'hc0);
		tick(20);
		check(vecs, 1);
		pev(9'h100);
		wr(8'h10, 8'h01);
		wait_cnt(0, 2);
		wr(8'h08, 8'h00);
		wr(8'h00, 8'h10);
		sleep_i <= 1;
		tick(2);
		external_irq_pin_i <= 0;
		wait_cnt(1, 1);
		rd(8'h00, 8'h12);
		sleep_i <= 0;
		tick(20);
		check(vecs, 2);
		wr(8'h24, 8'h02);
		tick(2);
		check({31'h0, irq_o}, 1);
		wr(8'h20, 8'h02);
		tick(2);
		check({31'h0, irq_o}, 0);
		wb_sel_i <= 4'h0;
		wr(8'h14, 8'hff);
		wb_sel_i <= 4'h1;
		rd(8'h14, 8'hbf);
		wr(8'h14, 8'hff);
		wr(8'h00, 8'h90);
		sleep_i <= 1;
		tick(2);
		external_irq_pin_i <= 1;
		wait_cnt(1, 2);
		sleep_i <= 0;
		wait_cnt(0, 3);
		rd(8'h00, 8'h12);
		rst_i <= 1;
		tick(2);
		rst_i <= 0;
		tick(5);
		rd(8'h00, 8'h00);
		rd(8'h14, 8'hff);
		print_verdict();
	end
endmodule
bind mcu_interrupt_controller irq_ctrl_monitor irq_ctrl_monitor_i (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .sleep_i, .return_from_irq_instr_i, .pc_i, .push_o, .push_pc_o, .pc_load_o,
	.pc_load_addr_o, .pop_o, .wake_o);
